// ### tfm_regs.svh
// Register offsets, limits, reset values and timing constants of the traverse modulator
`ifndef TFM_REGS_SVH
`define TFM_REGS_SVH
// ------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define TFM_OFS_MODE 8'h00
`define TFM_OFS_AMPL 8'h04
`define TFM_OFS_SCRAMBLE 8'h08
`define TFM_OFS_UP_TIME 8'h0c
`define TFM_OFS_DOWN_TIME 8'h10
`define TFM_OFS_HIGH_OFS 8'h14
`define TFM_OFS_LOW_OFS 8'h18
`define TFM_OFS_TERM_FUNC 8'h1c
`define TFM_OFS_REFERENCE 8'h20
`define TFM_OFS_STATUS 8'h24
`define TFM_OFS_OUTPUT 8'h28
// ------------------------------------------------------------
// Values, limits and reset defaults
// ------------------------------------------------------------
`define TFM_APP_NONE 3'h0
`define TFM_APP_TRAVERSE 3'h1
`define TFM_APP_PROC_LOOP 3'h2
`define TFM_APP_RESERVED 3'h3
`define TFM_APP_AUTO_SEQ 3'h4
`define TFM_FUNC_LOW_OFS 6'h1b
`define TFM_FUNC_HIGH_OFS 6'h1c
`define TFM_AMPL_MAX 10'h0c8
`define TFM_SCR_MAX 10'h1f4
`define TFM_OFS_MAX 10'h0c8
`define TFM_TIME_MIN 13'h0001
`define TFM_TIME_MAX 13'h1770
`define TFM_UP_RST 13'h0014
`define TFM_DOWN_RST 13'h001e
`define TFM_ZERO10 10'h000
`define TFM_TERMS 4'hb
// Percent fields hold tenths of a percent, times tenths of a second
`define TFM_PERMILLE 32'h0000_03e8
`define TFM_TENTH_NS 32'h05f5_e100
`define TFM_CLK_NS 32'h0000_0008
`endif

// ### tfm_pkg.sv
// Types shared by the traverse modulator files
package tfm_pkg;
   typedef enum logic [1:0] {TFM_IDLE, TFM_RISE, TFM_FALL} tfm_phase_t;
endpackage

// ### tfm_tick.sv
// Tenth-of-a-second tick generator for ramp timing
`include "tfm_regs.svh"
module tfm_tick import tfm_pkg::*; #(
   parameter int CLK_NS = 8, // Clock period in ns
   parameter int TENTH_CYCLES = 100_000_000 / CLK_NS // Cycles in 0.1 s
) (
   input wire logic clk, // Clock
   input wire logic rst, // Async reset, active high
   input wire logic run, // Counting enabled
   output logic tick // One-cycle pulse each 0.1 s
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [31:0] cnt; // Cycle counter
      logic tick; // Registered pulse
   } tfm_tick_st_t;
   tfm_tick_st_t s_q, s_d;
   // Counter wraps at the tenth-second count
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (!run) begin
         s_d.cnt = '0;
      end else if (s_q.cnt == 32'(TENTH_CYCLES - 1)) begin
         s_d.cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 32'h1;
      end
   end
   // Register the state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign tick = s_q.tick;
endmodule

// ### tfm_top.sv
// Traverse frequency modulator: oscillating winder profile around the reference
// Contract
// - Runs only when application selection equals one
// - Output varies periodically about the reference
// - Amplitude is 0 to 20 percent, default 0
// - Scramble drop at downward start, 0-50% amplitude
// - Separate ramp times 0.1-600 s, 2.0/3.0 default
// - High-offset terminal adds high offset amount
// - Low-offset terminal subtracts low offset amount
`include "tfm_regs.svh"
module tfm_top import tfm_pkg::*; #(
   parameter int TENTH_CYCLES = 12_500_000 // Cycles per 0.1 s at 125 MHz
) (
   input wire logic CLK, // Clock, 125 MHz
   input wire logic RST, // Async reset, active high
   input wire logic [7:0] ADDR, // Register byte address
   input wire logic [31:0] WDATA, // Write data
   input wire logic WR, // Write strobe
   input wire logic RD, // Read strobe
   output logic [31:0] RDATA, // Read data, cycle after RD
   input wire logic [10:0] TERM_IN, // Multi-function input terminals
   output logic [15:0] FREQ_CMD, // Motor frequency command
   output logic ACTIVE // Traverse running
);
   // ------------------------------------------------------------
   // State record
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] app_mode; // Application selection
      logic [9:0] ampl; // Amplitude, 0.1 %
      logic [9:0] scramble; // Scramble, 0.1 % of amplitude
      logic [12:0] up_time; // Ramp-up, 0.1 s
      logic [12:0] down_time; // Ramp-down, 0.1 s
      logic [9:0] high_ofs; // High offset, 0.1 %
      logic [9:0] low_ofs; // Low offset, 0.1 %
      logic [65:0] term_func; // 6-bit function per terminal
      logic [15:0] reference; // Frequency reference
      tfm_phase_t phase; // Profile phase
      logic [12:0] step; // Tenths elapsed in ramp
      logic [15:0] freq; // Frequency command
      logic active; // Running flag
      logic [31:0] rdata; // Read data
   } tfm_st_t;
   tfm_st_t s_q, s_d;
   logic tick; // 0.1 s pulse
   logic hi_on; // High offset terminal asserted
   logic lo_on; // Low offset terminal asserted
   logic signed [31:0] span; // Amplitude in frequency units
   logic signed [31:0] jump; // Scramble in frequency units
   logic signed [31:0] ofs; // Net offset
   logic signed [31:0] prof; // Profile before offset
   logic signed [31:0] sum; // Final unclamped frequency
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Clamp a 10-bit setting to its top limit
   function automatic logic [9:0] clamp10(input logic [31:0] v, input logic [9:0] mx);
      clamp10 = (v > 32'(mx)) ? mx : v[9:0];
   endfunction
   // Clamp a ramp time into 0.1..600.0 s
   function automatic logic [12:0] clamp_time(input logic [31:0] v);
      if (v < 32'(`TFM_TIME_MIN)) begin
         clamp_time = `TFM_TIME_MIN;
      end else if (v > 32'(`TFM_TIME_MAX)) begin
         clamp_time = `TFM_TIME_MAX;
      end else begin
         clamp_time = v[12:0];
      end
   endfunction
   // Any terminal with the given function code asserted
   function automatic logic term_hit(input logic [65:0] f, input logic [10:0] t, input logic [5:0] code);
      term_hit = 1'b0;
      for (int i = 0; i < `TFM_TERMS; i++) begin
         if (t[i] && f[i*6 +: 6] == code) begin
            term_hit = 1'b1;
         end
      end
   endfunction
   // Percent of the reference, in tenths of a percent
   function automatic logic signed [31:0] pct(input logic [15:0] r, input logic [9:0] p);
      pct = $signed(32'((32'(r) * 32'(p)) / `TFM_PERMILLE));
   endfunction
   // ------------------------------------------------------------
   // Timebase
   // ------------------------------------------------------------
   tfm_tick #(.CLK_NS(8), .TENTH_CYCLES(TENTH_CYCLES)) u_tick (
      .clk(CLK),
      .rst(RST),
      .run(s_q.active),
      .tick(tick)
   );
   // ------------------------------------------------------------
   // Profile arithmetic
   // ------------------------------------------------------------
   always_comb begin
      hi_on = term_hit(s_q.term_func, TERM_IN, `TFM_FUNC_HIGH_OFS);
      lo_on = term_hit(s_q.term_func, TERM_IN, `TFM_FUNC_LOW_OFS);
      span = pct(s_q.reference, s_q.ampl);
      jump = $signed(32'((32'(span) * 32'(s_q.scramble)) / `TFM_PERMILLE));
      ofs = (hi_on ? pct(s_q.reference, s_q.high_ofs) : 32'sh0)
         - (lo_on ? pct(s_q.reference, s_q.low_ofs) : 32'sh0);
      // Linear interpolation across the ramp; rise goes -A..+A, fall +A-jump..-A
      if (s_q.phase == TFM_RISE) begin
         prof = -span + $signed(32'((2 * 32'(span) * 32'(s_q.step)) / 32'(s_q.up_time)));
      end else if (s_q.phase == TFM_FALL) begin
         prof = span - jump
            - $signed(32'((32'(2 * span - jump) * 32'(s_q.step)) / 32'(s_q.down_time)));
      end else begin
         prof = 32'sh0;
      end
      sum = $signed({16'h0, s_q.reference}) + prof + ofs;
   end
   // ------------------------------------------------------------
   // Next state: registers, profile sequencer, readback
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rdata = '0;
      if (WR) begin
         case (ADDR)
            `TFM_OFS_MODE: s_d.app_mode = WDATA[2:0];
            `TFM_OFS_AMPL: s_d.ampl = clamp10(WDATA, `TFM_AMPL_MAX);
            `TFM_OFS_SCRAMBLE: s_d.scramble = clamp10(WDATA, `TFM_SCR_MAX);
            `TFM_OFS_UP_TIME: s_d.up_time = clamp_time(WDATA);
            `TFM_OFS_DOWN_TIME: s_d.down_time = clamp_time(WDATA);
            `TFM_OFS_HIGH_OFS: s_d.high_ofs = clamp10(WDATA, `TFM_OFS_MAX);
            `TFM_OFS_LOW_OFS: s_d.low_ofs = clamp10(WDATA, `TFM_OFS_MAX);
            `TFM_OFS_TERM_FUNC: begin
               // Word holds terminal index in [11:8] and code in [5:0]
               if (WDATA[11:8] < `TFM_TERMS) begin
                  s_d.term_func[WDATA[11:8]*6 +: 6] = WDATA[5:0];
               end
            end
            `TFM_OFS_REFERENCE: s_d.reference = WDATA[15:0];
            default: ; // Unmapped or read-only: ignored
         endcase
      end
      if (RD) begin
         case (ADDR)
            `TFM_OFS_MODE: s_d.rdata = {29'h0, s_q.app_mode};
            // Traverse settings read as zero unless traverse is selected
            `TFM_OFS_AMPL: s_d.rdata = s_q.active ? {22'h0, s_q.ampl} : '0;
            `TFM_OFS_SCRAMBLE: s_d.rdata = s_q.active ? {22'h0, s_q.scramble} : '0;
            `TFM_OFS_UP_TIME: s_d.rdata = s_q.active ? {19'h0, s_q.up_time} : '0;
            `TFM_OFS_DOWN_TIME: s_d.rdata = s_q.active ? {19'h0, s_q.down_time} : '0;
            `TFM_OFS_HIGH_OFS: s_d.rdata = s_q.active ? {22'h0, s_q.high_ofs} : '0;
            `TFM_OFS_LOW_OFS: s_d.rdata = s_q.active ? {22'h0, s_q.low_ofs} : '0;
            `TFM_OFS_REFERENCE: s_d.rdata = {16'h0, s_q.reference};
            `TFM_OFS_STATUS: s_d.rdata = {26'h0, lo_on, hi_on, 2'(s_q.phase), 1'b0, s_q.active};
            `TFM_OFS_OUTPUT: s_d.rdata = {16'h0, s_q.freq};
            default: s_d.rdata = '0; // Unmapped reads zero
         endcase
      end
      // Sequencer
      s_d.active = (s_q.app_mode == `TFM_APP_TRAVERSE);
      if (!s_q.active) begin
         s_d.phase = TFM_IDLE;
         s_d.step = '0;
      end else begin
         case (s_q.phase)
            TFM_IDLE: begin
               s_d.phase = TFM_RISE;
               s_d.step = '0;
            end
            TFM_RISE: begin
               if (tick) begin
                  // Peak is held one tenth so the top of the ramp is really reached
                  if (s_q.step >= s_q.up_time) begin
                     s_d.phase = TFM_FALL; // Jump applied at fall start
                     s_d.step = '0;
                  end else begin
                     s_d.step = s_q.step + 13'h1;
                  end
               end
            end
            TFM_FALL: begin
               if (tick) begin
                  if (s_q.step + 13'h1 >= s_q.down_time) begin
                     s_d.phase = TFM_RISE; // Cycle repeats
                     s_d.step = '0;
                  end else begin
                     s_d.step = s_q.step + 13'h1;
                  end
               end
            end
            default: s_d.phase = TFM_IDLE;
         endcase
      end
      // Negative results floor at zero; overflow saturates
      if (!s_q.active) begin
         s_d.freq = s_q.reference; // Plain reference when off
      end else if (sum < 0) begin
         s_d.freq = '0;
      end else if (sum > 32'sh0000_ffff) begin
         s_d.freq = 16'hffff;
      end else begin
         s_d.freq = sum[15:0];
      end
   end
   // Register the whole state
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s_q <= '{app_mode: `TFM_APP_NONE, ampl: `TFM_ZERO10, scramble: `TFM_ZERO10,
                  up_time: `TFM_UP_RST, down_time: `TFM_DOWN_RST, high_ofs: `TFM_ZERO10,
                  low_ofs: `TFM_ZERO10, term_func: '0, reference: '0, phase: TFM_IDLE,
                  step: '0, freq: '0, active: 1'b0, rdata: '0};
      end else begin
         s_q <= s_d;
      end
   end
   assign RDATA = s_q.rdata;
   assign FREQ_CMD = s_q.freq;
   assign ACTIVE = s_q.active;
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence seq_rise_end;
      s_q.phase == TFM_RISE && tick && (s_q.step >= s_q.up_time);
   endsequence
   a_active_follows_mode: assert property (@(posedge CLK) disable iff (RST)
      ACTIVE == ($past(s_q.app_mode) == `TFM_APP_TRAVERSE))
      else $error("active does not follow mode");
   a_idle_passes_ref: assert property (@(posedge CLK) disable iff (RST)
      !s_q.active |=> FREQ_CMD == $past(s_q.reference))
      else $error("inactive output not reference");
   a_ampl_limit: assert property (@(posedge CLK) disable iff (RST)
      s_q.ampl <= `TFM_AMPL_MAX) else $error("amplitude over limit");
   a_scramble_limit: assert property (@(posedge CLK) disable iff (RST)
      s_q.scramble <= `TFM_SCR_MAX) else $error("scramble over limit");
   a_time_range: assert property (@(posedge CLK) disable iff (RST)
      s_q.up_time >= `TFM_TIME_MIN && s_q.up_time <= `TFM_TIME_MAX
      && s_q.down_time >= `TFM_TIME_MIN && s_q.down_time <= `TFM_TIME_MAX)
      else $error("ramp time out of range");
   a_rise_to_fall: assert property (@(posedge CLK) disable iff (RST)
      seq_rise_end and s_q.active |=> s_q.phase == TFM_FALL && s_q.step == 13'h0)
      else $error("rise did not hand over to fall");
   a_fall_to_rise: assert property (@(posedge CLK) disable iff (RST)
      s_q.active && s_q.phase == TFM_FALL && tick && (s_q.step + 13'h1 >= s_q.down_time)
      |=> s_q.phase == TFM_RISE) else $error("fall did not repeat");
   a_hi_offset: assert property (@(posedge CLK) disable iff (RST)
      s_q.active && hi_on && !lo_on && sum >= 0 && sum <= 32'sh0000_ffff
      |=> FREQ_CMD == $past(sum[15:0])) else $error("high offset not applied");
   a_lo_sign: assert property (@(posedge CLK) disable iff (RST)
      lo_on && !hi_on |-> ofs <= 0) else $error("low offset not subtracted");
   // Rise must reach the full amplitude before the drop
   a_rise_peak: assert property (@(posedge CLK) disable iff (RST)
      s_q.active && s_q.phase == TFM_RISE && s_q.step == s_q.up_time |-> prof == span)
      else $error("rise did not reach peak");
   // Fall opens one scramble below the peak
   a_fall_jump: assert property (@(posedge CLK) disable iff (RST)
      s_q.active && s_q.phase == TFM_FALL && s_q.step == 13'h0 |-> prof == span - jump)
      else $error("fall did not open with jump");
   // Amplitude stays hidden while the traverse is off
   a_hidden_read: assert property (@(posedge CLK) disable iff (RST)
      RD && !s_q.active && ADDR == `TFM_OFS_AMPL |=> RDATA == 32'h0)
      else $error("setting visible while off");
endmodule

// ### tfm_term_model.sv
// Model of the external terminal switches feeding the modulator
module tfm_term_model (
   input wire logic clk, // Bench clock
   input wire logic [10:0] want, // Switch positions asked for by the bench
   output logic [10:0] term // Terminal levels seen by the drive
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // Switch contacts
   // ------------------------------------------------------------
   // Contacts change just after an edge, like a synchronous field input
   always @(posedge clk) begin
      term <= want; // Level held while the switch stays closed
   end
endmodule

// ### tfm_top_tb_top.sv
// Self-checking bench for the traverse frequency modulator
`include "tfm_regs.svh"
module tfm_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int TENTH = 4; // Short tick keeps the run brief
   logic clk, rst, wr, rd; // Clock, reset, strobes
   logic [7:0] addr; // Register address
   logic [31:0] wdata, rdata, got; // Bus data
   logic [10:0] want, term; // Switch positions
   logic [15:0] freq, mx, mn, aft; // Command and watched extremes
   logic active; // Running flag
   int err_count, cmp_count, cyc; // Tallies and timeout counter
   tfm_top #(.TENTH_CYCLES(TENTH)) u_tfm_top (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .TERM_IN(term), .FREQ_CMD(freq), .ACTIVE(active));
   tfm_term_model u_tfm_term_model (.clk(clk), .want(want), .term(term));
   // ------------------------------------------------------------
   // Clock and timeout
   // ------------------------------------------------------------
   initial clk = 1'b0;
   always #4 clk = ~clk;
   // Ceiling far above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         test_done();
      end
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Compare and count, reporting at once
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
   endtask
   // One-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read strobe, data taken in the following cycle only
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      rd_reg(a, got);
      chk(got, e);
   endtask
   // Watch the command; aft is the first value after leaving the top
   task automatic watch(input int n, input logic [15:0] top);
      logic [15:0] prev;
      mx = 16'h0000;
      mn = 16'hffff;
      aft = 16'h0000;
      prev = freq;
      repeat (n) begin
         @(negedge clk);
         if (freq > mx) mx = freq;
         if (freq < mn) mn = freq;
         if (prev === top && freq !== top && aft === 16'h0000) aft = freq;
         prev = freq;
      end
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0000_0000; want = 11'h000;
      err_count = 0; cmp_count = 0; cyc = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // Defaults, settings hidden while not in traverse mode
      rd_chk(`TFM_OFS_MODE, 32'h0000_0000);
      rd_chk(`TFM_OFS_UP_TIME, 32'h0000_0000);
      rd_chk(8'h3c, 32'h0000_0000);
      wr_reg(`TFM_OFS_REFERENCE, 32'h0000_03e8);
      repeat (2) @(negedge clk);
      chk({16'h0000, freq}, 32'h0000_03e8);
      $display("test defaults done");
      // Enter traverse, check defaults and clamping
      wr_reg(`TFM_OFS_MODE, 32'h0000_0001);
      repeat (2) @(negedge clk);
      chk({31'h0, active}, 32'h0000_0001);
      rd_chk(`TFM_OFS_UP_TIME, 32'h0000_0014);
      rd_chk(`TFM_OFS_DOWN_TIME, 32'h0000_001e);
      rd_chk(`TFM_OFS_AMPL, 32'h0000_0000);
      wr_reg(`TFM_OFS_AMPL, 32'h0000_012c);
      rd_chk(`TFM_OFS_AMPL, 32'h0000_00c8);
      wr_reg(`TFM_OFS_SCRAMBLE, 32'h0000_0258);
      rd_chk(`TFM_OFS_SCRAMBLE, 32'h0000_01f4);
      wr_reg(`TFM_OFS_UP_TIME, 32'h0000_0000);
      rd_chk(`TFM_OFS_UP_TIME, 32'h0000_0001);
      wr_reg(`TFM_OFS_DOWN_TIME, 32'h0000_1b58);
      rd_chk(`TFM_OFS_DOWN_TIME, 32'h0000_1770);
      $display("test settings done");
      // Profile: A = 100, J = 50, two tenths each way
      wr_reg(`TFM_OFS_AMPL, 32'h0000_0064);
      wr_reg(`TFM_OFS_UP_TIME, 32'h0000_0002);
      wr_reg(`TFM_OFS_DOWN_TIME, 32'h0000_0002);
      // A step left over from the long ramp needs one tick to retire
      repeat (8) @(posedge clk);
      watch(96, 16'h044c);
      chk({16'h0, mx}, 32'h0000_044c);
      chk({16'h0, mn}, 32'h0000_0384);
      chk({16'h0, aft}, 32'h0000_041a);
      $display("test profile done");
      // Offsets on terminals 3 (high) and 5 (low)
      wr_reg(`TFM_OFS_HIGH_OFS, 32'h0000_0032);
      wr_reg(`TFM_OFS_LOW_OFS, 32'h0000_0014);
      wr_reg(`TFM_OFS_TERM_FUNC, 32'h0000_031c);
      wr_reg(`TFM_OFS_TERM_FUNC, 32'h0000_051b);
      want <= 11'h008;
      repeat (4) @(posedge clk);
      watch(96, 16'h047e);
      chk({16'h0, mx}, 32'h0000_047e);
      chk({16'h0, mn}, 32'h0000_03b6);
      rd_reg(`TFM_OFS_STATUS, got);
      chk({31'h0, got[4]}, 32'h0000_0001);
      want <= 11'h020;
      repeat (4) @(posedge clk);
      watch(96, 16'h0438);
      chk({16'h0, mx}, 32'h0000_0438);
      chk({16'h0, mn}, 32'h0000_0370);
      rd_reg(`TFM_OFS_STATUS, got);
      chk({26'h0, got[5:4]}, 32'h0000_0002);
      want <= 11'h000;
      $display("test offsets done");
      // Every other selection stops the oscillation
      for (int m = 0; m < 5; m++) begin
         if (m != 1) begin
            wr_reg(`TFM_OFS_MODE, m);
            repeat (3) @(negedge clk);
            chk({31'h0, active}, 32'h0000_0000);
            chk({16'h0, freq}, 32'h0000_03e8);
            rd_chk(`TFM_OFS_AMPL, 32'h0000_0000);
         end
      end
      $display("test modes done");
      test_done();
   end
endmodule
